// [src/pin_cell_control_routing.sv]
// Peripheral control bus, wide nets and pin cell registers for one row edge
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Each pin cell can take clock, clear, capture gate and out gate from the bus.
// - The peripheral control bus holds twelve lines shared by all pin cells.
// - Up to eight out gates, six capture gates, two clocks, two clears.
// - Slots 0-5 are out gates; slots 6-11 capture gate or one alternate.
// - Beyond bus capacity, cells take gates straight from logic cells.
// - A cell may clock from either dedicated clock pin instead of the bus.
// - Each line is sourced from a dedicated pin or a cluster's first logic cell.
// - A logic cell in another row reaches a line through a column channel.
// - Chip-wide reset low clears every pin cell register asynchronously, overriding all.
// - With the option set, chip-wide enable low floats every pin.
// - Four shared slots can also drive the four wide nets.
// - An input cell drives two row channels.
// - An output cell picks its data from a subset of row channels.
// - At most eight pin cells per side of a row channel.
// - An input cell at a column end drives at most two column channels.
// - Two cells per column side, each muxing a distinct column channel subset.
// - Six dedicated low-skew input pins serve as control sources.
//////////////////////////////////////////////////////////////////////////////
module pin_cell_control_routing
	import pin_ctl_pkg::*;
(
	// Clock and chip-wide controls
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chipOutEnableOption,
	input wire logic chipOutEnable_n,
	// Line sources: dedicated pins, first logic cells, column-driven rows
	input wire logic [pin_ctl_pkg::DEDICATED_PINS-1:0] dedicatedPin,
	input wire logic [pin_ctl_pkg::CLUSTERS-1:0] clusterFirstCell,
	input wire logic [pin_ctl_pkg::COL_CHANNELS-1:0] colChannelIn,
	input wire logic [pin_ctl_pkg::CTRL_LINES*2-1:0] lineSourceSel,
	input wire logic [pin_ctl_pkg::CTRL_LINES*5-1:0] lineSourceIdx,
	// Slot usage: 1 selects the alternate function of a shared slot
	input wire logic [pin_ctl_pkg::SHARED_SLOTS-1:0] slotAlternate,
	input wire logic [pin_ctl_pkg::WIDE_NETS-1:0] wideNetInternal,
	// Per-cell configuration
	input wire logic [pin_ctl_pkg::CELLS*2-1:0] cellClockSel,
	input wire logic [pin_ctl_pkg::CELLS*2-1:0] cellClearSel,
	input wire logic [pin_ctl_pkg::CELLS*3-1:0] cellGateIdx,
	input wire logic [pin_ctl_pkg::CELLS*3-1:0] cellCaptureIdx,
	input wire logic [pin_ctl_pkg::CELLS-1:0] cellDirectGates,
	input wire logic [pin_ctl_pkg::CELLS-1:0] cellDirectOut,
	input wire logic [pin_ctl_pkg::CELLS-1:0] cellDirectCapture,
	input wire logic [pin_ctl_pkg::CELLS-1:0] cellIsOutput,
	input wire logic [pin_ctl_pkg::CELLS-1:0] cellFromColumn,
	input wire logic [pin_ctl_pkg::CELLS*5-1:0] cellTapSel,
	// Routing channels and pins
	input wire logic [pin_ctl_pkg::ROW_CHANNELS-1:0] rowChannelIn,
	input wire logic [pin_ctl_pkg::CELLS-1:0] pinIn,
	output logic [pin_ctl_pkg::CELLS-1:0] pinOut,
	output logic [pin_ctl_pkg::CELLS-1:0] pinOe,
	output logic [pin_ctl_pkg::CELLS*2-1:0] rowChannelOut,
	output logic [pin_ctl_pkg::CELLS*2-1:0] colChannelOut,
	output logic [pin_ctl_pkg::WIDE_NETS-1:0] wideNet
);
	import pin_ctl_pkg::*;

	typedef struct packed {
		logic [CELLS-1:0] data;
		logic [CELLS-1:0] oe;
		logic [CELLS-1:0] inCap;
		logic [CTRL_LINES-1:0] line;
		logic [WIDE_NETS-1:0] wide;
	} state_s;

	state_s st_reg;
	state_s st_next;
	logic [CTRL_LINES-1:0] lineNow;
	logic [OUT_GATES-1:0] outGate;
	logic [CAPTURE_GATES-1:0] capGate;
	logic clock0;
	logic clock1;
	logic clear0;
	logic clear1;

	//////////////////////////////////////////////////////////////////////////
	// Control line sourcing; one cycle of skew-equal staging for all lines
	always_comb begin
		for (int i = 0; i < CTRL_LINES; i++) begin
			logic [4:0] idx;
			idx = lineSourceIdx[i*5 +: 5];
			case (lineSourceSel[i*2 +: 2])
				2'h0: lineNow[i] = dedicatedPin[idx % DEDICATED_PINS];
				2'h1: lineNow[i] = clusterFirstCell[idx];
				default: lineNow[i] = colChannelIn[idx];
			endcase
		end
	end

	// Shared slot decode: a shared slot gives its capture gate or its alternate, not both
	always_comb begin
		outGate[OUT_GATE_SLOTS-1:0] = st_reg.line[OUT_GATE_SLOTS-1:0];
		for (int s = 0; s < SHARED_SLOTS; s++) begin
			capGate[s] = st_reg.line[OUT_GATE_SLOTS+s] & ~slotAlternate[s];
		end
		outGate[6] = st_reg.line[SLOT_GATE_6] & slotAlternate[SLOT_GATE_6-OUT_GATE_SLOTS];
		outGate[7] = st_reg.line[SLOT_GATE_7] & slotAlternate[SLOT_GATE_7-OUT_GATE_SLOTS];
		clock0 = st_reg.line[SLOT_CLOCK_0] & slotAlternate[SLOT_CLOCK_0-OUT_GATE_SLOTS];
		clock1 = st_reg.line[SLOT_CLOCK_1] & slotAlternate[SLOT_CLOCK_1-OUT_GATE_SLOTS];
		clear0 = st_reg.line[SLOT_CLEAR_0] & slotAlternate[SLOT_CLEAR_0-OUT_GATE_SLOTS];
		clear1 = st_reg.line[SLOT_CLEAR_1] & slotAlternate[SLOT_CLEAR_1-OUT_GATE_SLOTS];
	end

	//////////////////////////////////////////////////////////////////////////
	// Cell registers. Clocks are sampled as enables on clk: the selected
	// clock's rising edge is detected, since the design has one clock domain.
	logic [3:0] clkPrev_reg;
	logic [3:0] clkNow;
	assign clkNow = {dedicatedPin[1], dedicatedPin[0], clock1, clock0};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clkPrev_reg <= 4'h0;
		end else begin
			clkPrev_reg <= clkNow;
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.line = lineNow;
		st_next.wide = '0;
		st_next.wide[0] = wideNetInternal[0] ? st_reg.line[WIDE_SLOT_0] : dedicatedPin[2];
		st_next.wide[1] = wideNetInternal[1] ? st_reg.line[WIDE_SLOT_1] : dedicatedPin[3];
		st_next.wide[2] = wideNetInternal[2] ? st_reg.line[WIDE_SLOT_2] : dedicatedPin[4];
		st_next.wide[3] = wideNetInternal[3] ? st_reg.line[WIDE_SLOT_3] : dedicatedPin[5];
		for (int c = 0; c < CELLS; c++) begin
			logic edgeHit;
			logic gateOn;
			logic capOn;
			logic clrOn;
			logic [1:0] csel;
			logic [4:0] tap;
			logic dIn;
			clrOn = 1'b0;
			dIn = 1'b0;
			csel = cellClockSel[c*2 +: 2];
			edgeHit = clkNow[csel] & ~clkPrev_reg[csel];
			gateOn = cellDirectGates[c] ? cellDirectOut[c]
				: outGate[cellGateIdx[c*3 +: 3]];
			capOn = cellDirectGates[c] ? cellDirectCapture[c]
				: capGate[cellCaptureIdx[c*3 +: 3] % CAPTURE_GATES];
			case (cellClearSel[c*2 +: 2])
				2'h1: clrOn = clear0;
				2'h2: clrOn = clear1;
				default: clrOn = 1'b0;
			endcase
			tap = cellTapSel[c*5 +: 5];
			// Row cells see their own slice; column windows overlap but start at distinct offsets
			if (cellFromColumn[c]) begin
				dIn = colChannelIn[(c*2 + 32'(tap % COL_TAPS)) % COL_CHANNELS];
			end else begin
				dIn = rowChannelIn[c*ROW_TAPS + 32'(tap % ROW_TAPS)];
			end
			if (clrOn) begin
				st_next.data[c] = RESET_DATA;
				st_next.inCap[c] = RESET_DATA;
			end else if (edgeHit && capOn) begin
				st_next.data[c] = dIn;
				st_next.inCap[c] = pinIn[c];
			end
			st_next.oe[c] = cellIsOutput[c] & gateOn
				& ~(chipOutEnableOption & ~chipOutEnable_n);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	always_comb begin
		pinOut = st_reg.data;
		pinOe = st_reg.oe;
		wideNet = st_reg.wide;
		for (int c = 0; c < CELLS; c++) begin
			rowChannelOut[c*2 +: 2] = {2{st_reg.inCap[c]}};
			colChannelOut[c*2 +: 2] = {2{st_reg.inCap[c]}};
		end
	end
endmodule

// [common/pin_ctl_pkg.sv]
// Constants and types for the pin cell control and routing block
package pin_ctl_pkg;
	localparam int CTRL_LINES = 12;
	localparam int OUT_GATE_SLOTS = 6;
	localparam int SHARED_SLOTS = 6;
	localparam int OUT_GATES = 8;
	localparam int CAPTURE_GATES = 6;
	localparam int DEDICATED_PINS = 6;
	localparam int WIDE_NETS = 4;
	localparam int ROW_CHANNELS = 144;
	localparam int ROW_TAPS = 18;
	localparam int COL_CHANNELS = 24;
	localparam int COL_TAPS = 16;
	localparam int ROWS = 3;
	localparam int CELLS = 8;
	localparam int CLUSTERS = 24;
	// Slot index of each shared alternate function
	localparam int SLOT_CLOCK_0 = 6;
	localparam int SLOT_GATE_6 = 7;
	localparam int SLOT_CLEAR_0 = 8;
	localparam int SLOT_GATE_7 = 9;
	localparam int SLOT_CLEAR_1 = 10;
	localparam int SLOT_CLOCK_1 = 11;
	// Slot feeding each wide net
	localparam int WIDE_SLOT_0 = 6;
	localparam int WIDE_SLOT_1 = 7;
	localparam int WIDE_SLOT_2 = 9;
	localparam int WIDE_SLOT_3 = 11;
	localparam logic RESET_DATA = 1'b0;
	localparam logic [CELLS-1:0] RESET_CELLS = 8'h00;

	typedef enum logic [1:0] {CLK_BUS0, CLK_BUS1, CLK_PIN0, CLK_PIN1} clock_src_e;
	typedef enum logic [1:0] {CLR_NONE, CLR_BUS0, CLR_BUS1} clear_src_e;
endpackage

// [verif/pin_board_model.sv]
// Board side model driving the dedicated input pins
module pin_board_model
(
	// Clock and requested levels
	input wire logic clk,
	input wire logic clkPulse,
	input wire logic gateLvl,
	input wire logic oeLvl,
	input wire logic netLvl,
	// Board pins
	output logic [pin_ctl_pkg::DEDICATED_PINS-1:0] dedicatedPin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Spare clock pin and pin 3 tied to ground, never left floating
	always @(posedge clk) begin
		dedicatedPin <= {gateLvl, oeLvl, 1'b0, netLvl, 1'b0, clkPulse};
	end
endmodule

// [verif/pin_ctl_monitor.sv]
// Port checks for the pin cell control block
module pin_ctl_monitor
(
	// Clock, reset and controls
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chipOutEnableOption,
	input wire logic chipOutEnable_n,
	input wire logic [5:0] dedicatedPin,
	input wire logic [3:0] wideNetInternal,
	input wire logic [15:0] cellClockSel,
	input wire logic [15:0] cellClearSel,
	// Outputs
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [15:0] rowChannelOut,
	input wire logic [3:0] wideNet
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	// Reset is checked without disable, it must win over everything
	reset_zero_a: assert property (
		!reset_n |-> pinOut == 0 && pinOe == 0 && rowChannelOut == 0 && wideNet == 0)
		else $error("outputs not clear in reset");
	reset_exit_a: assert property ($rose(reset_n) |-> pinOut == 0 && pinOe == 0)
		else $error("outputs not clear after reset");
	chip_float_a: assert property (disable iff (!reset_n)
		(chipOutEnableOption && !chipOutEnable_n) [*3] |-> pinOe == 0)
		else $error("pins driven while chip disabled");
	oe_rise_a: assert property (disable iff (!reset_n)
		$rose(pinOe[0]) |-> !$past(chipOutEnableOption && !chipOutEnable_n))
		else $error("drive rose during chip disable");
	wide_net0_a: assert property (disable iff (!reset_n)
		(!wideNetInternal[0] && $stable(dedicatedPin[2])) [*3] |-> wideNet[0] == dedicatedPin[2])
		else $error("wide net 0 not following pin");
	wide_net3_a: assert property (disable iff (!reset_n)
		(!wideNetInternal[3] && $stable(dedicatedPin[5])) [*3] |-> wideNet[3] == dedicatedPin[5])
		else $error("wide net 3 not following pin");
	row_pair_a: assert property (disable iff (!reset_n)
		rowChannelOut[0] == rowChannelOut[1] && rowChannelOut[14] == rowChannelOut[15])
		else $error("row channel pair differs");
	no_edge_hold_a: assert property (disable iff (!reset_n)
		(cellClockSel == 16'hAAAA && cellClearSel == 0 && !dedicatedPin[0]) [*5]
		|-> $stable(rowChannelOut)) else $error("capture without clock edge");
	cover property ($changed(rowChannelOut));
	cover property ((chipOutEnableOption && !chipOutEnable_n) [*3]);
	cover property ($rose(wideNet[0]));
endmodule
bind pin_cell_control_routing pin_ctl_monitor mon_u (.clk(clk), .reset_n(reset_n),
	.chipOutEnableOption(chipOutEnableOption), .chipOutEnable_n(chipOutEnable_n),
	.dedicatedPin(dedicatedPin), .wideNetInternal(wideNetInternal), .pinOut(pinOut),
	.cellClockSel(cellClockSel), .cellClearSel(cellClearSel), .pinOe(pinOe),
	.rowChannelOut(rowChannelOut), .wideNet(wideNet));

// [verif/pin_cell_control_routing_tb.sv]
// Self-checking bench for the pin cell control block
module pin_cell_control_routing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Reset starts high and falls at time zero, so the async reset edge is seen
	logic clk = 0, reset_n = 1, opt = 0, enN = 1, pulse = 0, gate = 0, oe = 0, net = 0;
	logic [23:0] colIn = 24'h00_0000;
	logic [59:0] lsIdx = 60'h000_0001_4000_0004;
	logic [15:0] ckSel = 16'hAAAA, clrSel = 16'h0000;
	logic [7:0] dirG = 8'h00, dirO = 8'h00, dirC = 8'h00, fromCol = 8'h00;
	logic [5:0] alt = 6'h00;
	logic [3:0] wInt = 4'h0;
	localparam int SEL_ROW = 0;
	localparam int SEL_PINS = 1;
	localparam int SEL_WIDE = 2;
	logic [7:0] pinIn = 0, isOut = 0, pinOut, pinOe;
	logic [143:0] rowIn = 0;
	logic [15:0] rowOut;
	logic [5:0] dPin;
	logic [3:0] wideNet;
	int mismatches = 0, checksDone = 0;
	always #20 clk = ~clk;
	pin_board_model board_u (.clk(clk), .clkPulse(pulse), .gateLvl(gate), .oeLvl(oe),
		.netLvl(net), .dedicatedPin(dPin));
	// Out gate 0 from pin 4, capture gate 0 from pin 5, all cells clocked by pin 0
	pin_cell_control_routing dut_u (.clk(clk), .reset_n(reset_n), .chipOutEnableOption(opt),
		.chipOutEnable_n(enN), .dedicatedPin(dPin), .clusterFirstCell(24'h00_0000),
		.colChannelIn(colIn), .lineSourceSel(24'h00_0000), .lineSourceIdx(lsIdx),
		.slotAlternate(alt), .wideNetInternal(wInt), .cellClockSel(ckSel),
		.cellClearSel(clrSel), .cellGateIdx(24'h00_0000), .cellCaptureIdx(24'h00_0000),
		.cellDirectGates(dirG), .cellDirectOut(dirO), .cellDirectCapture(dirC),
		.cellIsOutput(isOut), .cellFromColumn(fromCol), .cellTapSel(40'h00_0000_0000),
		.rowChannelIn(rowIn),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .rowChannelOut(rowOut),
		.colChannelOut(), .wideNet(wideNet));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Outputs are read at the falling edge, then the bench returns to a rising edge
	task automatic chk(input int sel, input logic [15:0] exp);
		logic [15:0] got;
		@(negedge clk);
		if (sel == SEL_ROW) begin
			got = rowOut;
		end else if (sel == SEL_PINS) begin
			got = {pinOe, pinOut};
		end else begin
			got = {12'h000, wideNet};
		end
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
		@(posedge clk);
	endtask
	task automatic edge_pin0();
		pulse <= 1;
		tick(1);
		pulse <= 0;
		tick(6);
	endtask
	task automatic test_capture();
		gate <= 1;
		pinIn <= 8'h5A;
		tick(3);
		edge_pin0();
		chk(SEL_ROW, 16'h33CC);
		gate <= 0;
		pinIn <= 8'hC3;
		tick(3);
		edge_pin0();
		chk(SEL_ROW, 16'h33CC);
		$display("test capture done");
	endtask
	task automatic test_output();
		gate <= 1;
		oe <= 1;
		isOut <= 8'hFF;
		for (int c = 0; c < 8; c++) rowIn[c*18] <= c[0] ^ c[1] ^ c[2];
		tick(3);
		edge_pin0();
		chk(SEL_PINS, 16'hFF96);
		opt <= 1;
		enN <= 0;
		tick(3);
		chk(SEL_PINS, 16'h0096);
		enN <= 1;
		tick(3);
		chk(SEL_PINS, 16'hFF96);
		$display("test output done");
	endtask
	task automatic test_wide();
		net <= 1;
		gate <= 0;
		tick(4);
		chk(SEL_WIDE, 16'h0005);
		net <= 0;
		gate <= 1;
		oe <= 0;
		tick(4);
		chk(SEL_WIDE, 16'h0008);
		reset_n <= 0;
		tick(1);
		chk(SEL_PINS, 16'h0000);
		chk(SEL_ROW, 16'h0000);
		reset_n <= 1;
		$display("test wide and reset done");
	endtask
	// Slot 6 as bus clock 0, slot 8 as clear 0, gates straight from logic cells
	task automatic test_alt();
		tick(2);
		lsIdx <= 60'h000_0000_0000_0004;
		alt <= 6'h01;
		ckSel <= 16'h0000;
		dirG <= 8'hFF;
		dirO <= 8'hFF;
		dirC <= 8'hFF;
		fromCol <= 8'hFF;
		colIn <= 24'h55_5555;
		wInt <= 4'h1;
		net <= 1;
		pinIn <= 8'hA5;
		tick(3);
		chk(SEL_WIDE, 16'h0008);
		edge_pin0();
		chk(SEL_PINS, 16'hFFFF);
		chk(SEL_ROW, 16'hCC33);
		clrSel <= 16'h5555;
		alt <= 6'h05;
		pinIn <= 8'hFF;
		tick(3);
		edge_pin0();
		chk(SEL_ROW, 16'h0000);
		chk(SEL_PINS, 16'hFF00);
		$display("test alternate done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	initial begin
		reset_n <= 0;
		tick(11);
		chk(SEL_PINS, 16'h0000);
		reset_n <= 1;
		tick(2);
		test_capture();
		test_output();
		test_wide();
		test_alt();
		give_verdict();
	end
endmodule
